// ### hw/ref_select_and_cal_regs.sv
// Purpose: Register bank for sensor offset, reference select and regulator control.
// Assumes: One clock; sfr_wr and sfr_rd are single-cycle strobes from core logic.
// Notes: Read data is registered and appears one cycle after the read strobe.
`timescale 1ns/1ps
module ref_select_and_cal_regs
   import ref_cal_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [9:0] cal_offset,
   output logic [7:0] sfr_rdata,
   output logic [1:0] ref_source,
   output logic sensor_enable,
   output logic stop_power_config,
   output logic regulator_bypass,
   output logic regulator_off,
   output logic pin_reset_only
);

   // Calibration word from non-volatile store, read only after reset release.
   logic load_pending_reg;
   // Offset storage; the bits of the low byte that always read zero are not stored.
   logic [9:0] zero_point_reg;
   logic [9:0] zero_point_next;
   // Reference control storage, all eight bits kept; the unused ones stay zero through the write mask.
   logic [7:0] ref_ctrl_reg;
   logic [7:0] ref_ctrl_next;
   // Regulator control, all eight bits read-write.
   logic [7:0] reg_ctrl_reg;
   logic [7:0] read_next;
   logic [1:0] ref_source_next;
   ref_source_t src_sel;

   // Address decode as named wires.
   wire hit_low = sfr_addr == ADDR_OFFSET_LOW;
   wire hit_high = sfr_addr == ADDR_OFFSET_HIGH;
   wire hit_ref = sfr_addr == ADDR_REF_CTRL;
   wire hit_reg = sfr_addr == ADDR_REG_CTRL;
   wire [7:0] low_view = {zero_point_reg[1:0], 6'h00};
   wire [7:0] high_view = zero_point_reg[9:2];

   // Offset next value: calibration load takes precedence, then software writes.
   always_comb
   begin
      zero_point_next = zero_point_reg;
      if (load_pending_reg)
      begin
         zero_point_next = cal_offset;
      end
      else if (sfr_wr && hit_high)
      begin
         zero_point_next[9:2] = sfr_wdata;
      end
      else if (sfr_wr && hit_low)
      begin
         // Only bits 7:6 land; the rest are dropped.
         zero_point_next[1:0] = sfr_wdata[LOW_OFFSET_MSB:LOW_OFFSET_LSB];
      end
   end

   // Unused bits are masked away on write so they always read zero.
   assign ref_ctrl_next = (sfr_wr && hit_ref) ? (sfr_wdata & REF_CTRL_MASK) : ref_ctrl_reg;

   // Override wins over the select bit.
   always_comb
   begin
      if (ref_ctrl_next[REF_OVERRIDE_BIT])
      begin
         src_sel = REF_REGULATOR;
      end
      else if (ref_ctrl_next[REF_SELECT_BIT])
      begin
         src_sel = REF_SUPPLY;
      end
      else
      begin
         src_sel = REF_PIN;
      end
   end
   assign ref_source_next = src_sel;

   // Read multiplexer; unmapped addresses read zero.
   assign read_next = hit_low ? low_view :
                      hit_high ? high_view :
                      hit_ref ? ref_ctrl_reg :
                      hit_reg ? reg_ctrl_reg : 8'h00;

   // Calibration load sequencing; the cal port is sampled only after release, never in reset.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         load_pending_reg <= 1'b1;
         zero_point_reg <= OFFSET_RESET;
      end
      else
      begin
         load_pending_reg <= 1'b0;
         zero_point_reg <= zero_point_next;
      end
   end

   // Control registers, cleared by reset.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ref_ctrl_reg <= REF_CTRL_RESET;
         reg_ctrl_reg <= REG_CTRL_RESET;
      end
      else
      begin
         ref_ctrl_reg <= ref_ctrl_next;
         if (sfr_wr && hit_reg)
         begin
            reg_ctrl_reg <= sfr_wdata;
         end
      end
   end

   // Outputs come straight from flip-flops, updated together with the register.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sfr_rdata <= 8'h00;
         ref_source <= REF_PIN;
         sensor_enable <= 1'b0;
         stop_power_config <= 1'b0;
         regulator_bypass <= 1'b0;
         regulator_off <= 1'b0;
         pin_reset_only <= 1'b0;
      end
      else
      begin
         sfr_rdata <= sfr_rd ? read_next : 8'h00;
         ref_source <= ref_source_next;
         sensor_enable <= ref_ctrl_next[SENSOR_ENABLE_BIT];
         if (sfr_wr && hit_reg)
         begin
            // Clear keeps the regulator alive in stop; set shuts it down there.
            stop_power_config <= sfr_wdata[STOP_CONFIG_BIT];
            pin_reset_only <= sfr_wdata[STOP_CONFIG_BIT];
            // Bypass must only be used with an external regulator; hardware cannot check it.
            regulator_bypass <= sfr_wdata[BYPASS_BIT];
            regulator_off <= sfr_wdata[BYPASS_BIT];
         end
      end
   end

   // Checks.
   low_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit_low |=> sfr_rdata[5:0] == 6'h00)
      else $error("Low offset unused bits not zero.");
   high_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit_high && !sfr_wr && !load_pending_reg |=> sfr_rdata == $past(zero_point_reg[9:2]))
      else $error("High offset read mismatch.");
   low_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sfr_rd && hit_low && !load_pending_reg |=> sfr_rdata[7:6] == $past(zero_point_reg[1:0]))
      else $error("Low offset read mismatch.");
   cal_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      load_pending_reg |=> zero_point_reg == $past(cal_offset))
      else $error("Calibration not loaded.");
   ref_unused_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (ref_ctrl_reg & ~REF_CTRL_MASK) == 8'h00)
      else $error("Reference unused bits set.");
   override_src_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ref_ctrl_reg[REF_OVERRIDE_BIT] |-> ref_source == REF_REGULATOR)
      else $error("Override not honoured.");
   select_src_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !ref_ctrl_reg[REF_OVERRIDE_BIT] |-> ref_source == (ref_ctrl_reg[REF_SELECT_BIT] ? REF_SUPPLY : REF_PIN))
      else $error("Select not honoured.");
   sensor_en_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sensor_enable == ref_ctrl_reg[SENSOR_ENABLE_BIT])
      else $error("Sensor enable mismatch.");
   stop_cfg_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      stop_power_config == reg_ctrl_reg[STOP_CONFIG_BIT] && pin_reset_only == stop_power_config)
      else $error("Stop config mismatch.");
   bypass_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit_reg |=> regulator_off == $past(sfr_wdata[BYPASS_BIT]) && regulator_bypass == regulator_off)
      else $error("Bypass not applied.");
   reg_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sfr_wr && hit_reg ##1 sfr_rd && hit_reg && !sfr_wr |=> sfr_rdata == $past(sfr_wdata, 2))
      else $error("Regulator control readback mismatch.");
   cov_override_c: cover property (@(posedge clk_sys) disable iff (!nrst) ref_source == REF_REGULATOR);
   cov_supply_c: cover property (@(posedge clk_sys) disable iff (!nrst) ref_source == REF_SUPPLY);
   cov_stop_c: cover property (@(posedge clk_sys) disable iff (!nrst) stop_power_config && regulator_bypass);
   cov_low_wr_c: cover property (@(posedge clk_sys) disable iff (!nrst) sfr_wr && hit_low ##1 sfr_rd && hit_low);

endmodule // ref_select_and_cal_regs

// ### include/ref_cal_pkg.sv
// Purpose: Constants shared by the reference, regulator and sensor offset register bank.
// Assumes: Byte-wide special-function-register access on clk_sys.
// Notes: Offsets are the special-function addresses of the registers.
// Notes on behaviour
// - High offset register holds offset bits nine..two.
// - Low register bits 7:6 hold offset bits 1:0.
// - Low register bits 5:0 read zero, ignore writes.
// - Offset equals sensor reading at zero degrees.
// - Select bit picks reference pin or supply.
// - Override bit forces internal regulator as reference.
// - Reference control bit 2 enables sensor.
// - Unused reference control bits read zero.
// - Stop config clear keeps regulator running in stop.
// - Stop config set shuts regulator in stop.
// - Bypass bit turns regulator off, bypass mode.
// - Regulator control bits 7,6; reset clears register.
package ref_cal_pkg;
   // Register addresses.
   localparam logic [7:0] ADDR_OFFSET_LOW = 8'h85;
   localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h86;
   localparam logic [7:0] ADDR_REF_CTRL = 8'hd1;
   localparam logic [7:0] ADDR_REG_CTRL = 8'hc7;
   // Field positions.
   localparam int LOW_OFFSET_MSB = 7;
   localparam int LOW_OFFSET_LSB = 6;
   localparam int REF_OVERRIDE_BIT = 4;
   localparam int REF_SELECT_BIT = 3;
   localparam int SENSOR_ENABLE_BIT = 2;
   localparam int STOP_CONFIG_BIT = 7;
   localparam int BYPASS_BIT = 6;
   // Writable-bit masks and reset values.
   localparam logic [7:0] REF_CTRL_MASK = 8'h1c;
   localparam logic [7:0] LOW_MASK = 8'hc0;
   localparam logic [7:0] REF_CTRL_RESET = 8'h00;
   localparam logic [7:0] REG_CTRL_RESET = 8'h00;
   localparam logic [9:0] OFFSET_RESET = 10'h000;
   // Reference source codes driven to the analog multiplexer.
   typedef enum logic [1:0]
   {
      REF_PIN = 2'b00,
      REF_SUPPLY = 2'b01,
      REF_REGULATOR = 2'b10
   } ref_source_t;
endpackage

// ### verification/testbench.sv
// Purpose: Self-checking bench for the reference, regulator and sensor offset register bank.
// Assumes: Inputs change on the falling edge; read data is valid one cycle after its strobe.
// Notes: Expected read data waits in a queue until the monitor sees the answer.
`timescale 1ns/1ps
module testbench;
   import ref_cal_pkg::*;
   logic clk_sys, nrst, sfr_wr, sfr_rd, rd_seen;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
   logic [9:0] cal_offset;
   logic [1:0] ref_source;
   logic sensor_enable, stop_power_config, regulator_bypass, regulator_off, pin_reset_only;
   logic [31:0] seed = 32'h00000052; // Fixed seed keeps every run identical.
   logic [7:0] exp_q[$]; // Read data still owed by the design.
   int err_total = 0;
   int checks = 0;

   ref_select_and_cal_regs i_ref_select_and_cal_regs (.clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .cal_offset(cal_offset), .sfr_rdata(sfr_rdata),
      .ref_source(ref_source), .sensor_enable(sensor_enable), .stop_power_config(stop_power_config),
      .regulator_bypass(regulator_bypass), .regulator_off(regulator_off), .pin_reset_only(pin_reset_only));

   // The clock runs at 100 MHz.
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Xorshift source for data bytes.
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   // Compares one value and counts the comparison.
   task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // A write strobe lasts one cycle, then one idle cycle so no signal is set twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
      @(negedge clk_sys);
   endtask

   // A read notes its expected answer before the strobe is taken.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      @(negedge clk_sys);
   endtask

   // A write followed at the very next edge by a read of the same place; each strobe changes once.
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      exp_q.push_back(e);
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      @(negedge clk_sys);
   endtask

   // The monitor remembers a taken strobe and checks the answer half a cycle later.
   always @(posedge clk_sys) rd_seen <= sfr_rd;
   always @(negedge clk_sys)
      if (rd_seen === 1'b1)
      begin
         chk("sfr_rdata", {2'b00, sfr_rdata}, {2'b00, exp_q.pop_front()});
      end

   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("Checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence.
   initial
   begin
      {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
      d = rnd();
      cal_offset = {rnd(), d[1:0]}; // Held stable through every reset.
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("outputs", {3'b000, ref_source, sensor_enable, stop_power_config, regulator_bypass, regulator_off,
         pin_reset_only}, 10'h000);
      rd(ADDR_REF_CTRL, REF_CTRL_RESET);
      rd(ADDR_REG_CTRL, REG_CTRL_RESET);
      rd(ADDR_OFFSET_HIGH, cal_offset[9:2]);
      rd(ADDR_OFFSET_LOW, {cal_offset[1:0], 6'h00});
      // Every override, select and enable code, with noise in the unused bits.
      for (int i = 0; i < 8; i++)
      begin
         d = rnd();
         d[4:2] = i[2:0];
         wr(ADDR_REF_CTRL, d);
         chk("ref_source", {8'h00, ref_source}, {8'h00, d[4] ? REF_REGULATOR : (d[3] ? REF_SUPPLY : REF_PIN)});
         chk("sensor_enable", {9'h000, sensor_enable}, {9'h000, d[2]});
         rd(ADDR_REF_CTRL, d & REF_CTRL_MASK);
      end
      // All four stop and bypass settings.
      for (int i = 0; i < 4; i++)
      begin
         d = rnd();
         d[7:6] = i[1:0];
         wr(ADDR_REG_CTRL, d);
         chk("regulator_flags", {6'h00, stop_power_config, pin_reset_only, regulator_bypass, regulator_off},
            {6'h00, d[7], d[7], d[6], d[6]});
         rd(ADDR_REG_CTRL, d);
      end
      d = rnd();
      wr(ADDR_OFFSET_LOW, d);
      rd(ADDR_OFFSET_LOW, d & LOW_MASK);
      wr(ADDR_OFFSET_HIGH, d);
      rd(ADDR_OFFSET_HIGH, d);
      // Back-to-back write and read: the new value must be visible at once.
      d = rnd();
      wr_rd(ADDR_REG_CTRL, d, d);
      d = rnd();
      wr_rd(ADDR_OFFSET_LOW, d, d & LOW_MASK);
      // An unmapped place reads zero and keeps nothing.
      wr(8'h87, 8'hff);
      rd(8'h87, 8'h00);
      // A second reset clears the controls and reloads the calibration word.
      nrst = 1'b0;
      @(negedge clk_sys);
      chk("reset_outputs", {5'h00, stop_power_config, pin_reset_only, regulator_bypass, regulator_off, sensor_enable},
         10'h000);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rd(ADDR_OFFSET_HIGH, cal_offset[9:2]);
      finish_test();
   end

   // Watchdog: the sequence needs well under 200 cycles.
   initial
   begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule // testbench
